// File: core/thbp_pkg.sv
// thbp_pkg: constants for the timer host bus port.
// assumes one 40 MHz clock domain and a 16-bit internal register bus.
package thbp_pkg;
	localparam int          DB_W          = 16;
	localparam int          NUM_CNT       = 5;
	localparam int          NUM_REGS      = 18;
	localparam int          PIN_W         = 20;
	// register indices: counter n uses (n-1)*3 + {mode, load, hold}
	localparam logic [4:0]  IDX_ALARM1    = 5'h0f;
	localparam logic [4:0]  IDX_ALARM2    = 5'h10;
	localparam logic [4:0]  IDX_GCTL      = 5'h11;
	localparam logic [4:0]  IDX_NONE      = 5'h1e;
	localparam logic [4:0]  IDX_STATUS    = 5'h1f;
	// data pointer fields
	localparam logic [2:0]  GRP_CTL       = 3'h7;
	localparam logic [2:0]  GRP_LAST      = 3'h5;
	localparam logic [2:0]  GRP_RST       = 3'h1;
	localparam logic [1:0]  EL_MODE       = 2'h0;
	localparam logic [1:0]  EL_LOAD       = 2'h1;
	localparam logic [1:0]  EL_HOLD       = 2'h2;
	localparam logic [1:0]  EL_HOLDC      = 2'h3;
	localparam logic [1:0]  EL_RST        = 2'h0;
	// global_control bit positions and reset
	localparam int          FOUT_GATE_BIT = 12;
	localparam int          BUS_WIDTH_BIT = 13;
	localparam int          SEQ_DIS_BIT   = 14;
	localparam logic [15:0] GCTL_RST      = 16'h0000;
	localparam logic [15:0] REG_RST       = 16'h0000;
	localparam logic [15:0] DB_RST        = 16'h0000;
	// pin vector {cs_n, rd_n, wr_n, cd, db[15:0]} idles with strobes high
	localparam logic [19:0] PIN_RST       = 20'hf0000;
	localparam int          PIN_CS        = 19;
	localparam int          PIN_RD        = 18;
	localparam int          PIN_WR        = 17;
	localparam int          PIN_CD        = 16;
	// command codes
	localparam logic [7:0]  CMD_MRESET    = 8'hff;
	localparam logic [7:0]  CMD_FOUT_OFF  = 8'hee;
	localparam logic [7:0]  CMD_FOUT_ON   = 8'he6;
	localparam logic [7:0]  CMD_BUS16     = 8'hef;
	localparam logic [7:0]  CMD_BUS8      = 8'he7;
	localparam logic [7:0]  CMD_SEQ_OFF   = 8'he8;
	localparam logic [7:0]  CMD_SEQ_ON    = 8'he0;
	localparam logic [2:0]  CMD_LDPTR_TOP = 3'h0;
	localparam logic [7:0]  CMD_RST       = 8'h00;
endpackage : thbp_pkg

// File: core/thbp_host_port.sv
// thbp_host_port: strobe-driven host port with data pointer and prefetch.
// assumes async host pins, counter outputs on sys_clk, 16-bit register file.
//
// Summary of operation
// R1: host never lowers read and write together
// R2: chip select high ignores all strobes
// R3: data port reads or writes pointed register
// R4: control port reads status, writes command
// R5: host holds unused upper command lines high
// R6: host pulses write low with stable address
// R7: load pointer command sets byte pointer one
// R8: pointer auto-sequences when sequencing bit clear
// R9: gate, width, sequencing bits set by commands
// R10: control status read follows counter outputs
// R11: 8-bit host writes low byte first
// R12: low byte on low lines; high only 16-bit
// R13: data read stays stable, served from prefetch
// R14: status via data port repeats in 8-bit
// R15: select lines may stay low between transfers
// R16: host reloads pointer after other commands
// R17: host sets pointer once per sequence
// R18: both hold codes select the same register, except in the control group
// R19: data port reaches counter, alarm, control registers
// R20: reset or master reset clears global control
// R21: 8-bit mode toggles byte pointer per byte
// R22: data port completions and load pointer commands update pointer and prefetch
// R23: one write per strobe, acted on release
`timescale 1ns/1ps
module thbp_host_port (
	input  wire logic                       sys_clk,        // 40 MHz clock
	input  wire logic                       rst_n,          // async reset
	input  wire logic                       cs_n,           // chip select pin
	input  wire logic                       rd_n,           // read strobe pin
	input  wire logic                       wr_n,           // write strobe pin
	input  wire logic                       cd,             // high: control port
	input  wire logic [thbp_pkg::DB_W-1:0]  db_in,          // data bus in
	input  wire logic [thbp_pkg::NUM_CNT-1:0] cnt_out,      // counter outputs
	output logic      [thbp_pkg::DB_W-1:0]  db_out,         // data bus out
	output logic                            db_oe_lo,       // drive lines 7:0
	output logic                            db_oe_hi,       // drive lines 15:8
	output logic      [thbp_pkg::DB_W-1:0]  global_control, // control register
	output logic      [7:0]                 cmd_code,       // last command
	output logic                            cmd_stb         // command pulse
);
	import thbp_pkg::*;

	// map pointer fields onto a register index; both hold codes agree outside the control group
	function automatic logic [4:0] reg_idx(input logic [2:0] g, input logic [1:0] e);
		logic [4:0] base;
		base = 5'({g, 1'b0}) + 5'(g) - 5'h3;
		if (g == GRP_CTL) begin
			reg_idx = (e == EL_MODE) ? IDX_ALARM1 : (e == EL_LOAD) ? IDX_ALARM2 :
				(e == EL_HOLD) ? IDX_GCTL : IDX_STATUS;
		end else if (g == 3'h0 || g > GRP_LAST) begin
			reg_idx = IDX_NONE;
		end else begin
			reg_idx = base + ((e == EL_MODE) ? 5'h0 : (e == EL_LOAD) ? 5'h1 : 5'h2); // R18
		end
	endfunction : reg_idx

	// next pointer of the auto-sequence cycle
	function automatic logic [4:0] seq_next(input logic [2:0] g, input logic [1:0] e);
		logic [2:0] gn;
		gn = (g >= GRP_LAST) ? GRP_RST : g + 3'h1;
		if (g == GRP_CTL) begin
			seq_next = (e == EL_HOLDC) ? {g, e} : {g, (e == EL_HOLD) ? EL_MODE : e + 2'h1};
		end else if (e == EL_HOLDC) begin
			seq_next = {gn, e};
		end else if (e == EL_HOLD) begin
			seq_next = {gn, EL_MODE};
		end else begin
			seq_next = {g, e + 2'h1};
		end
	endfunction : seq_next

	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	logic [PIN_W-1:0] pin_d_r;
	logic [15:0]      regs_r   [NUM_REGS];
	logic [15:0]      regs_nxt [NUM_REGS];
	logic [2:0]       grp_r, grp_nxt;
	logic [1:0]       el_r, el_nxt;
	logic             bptr_r, bptr_nxt;
	logic [15:0]      pf_r, pf_nxt;
	logic             pf_pend_r, pf_pend_nxt;
	logic [15:0]      db_out_r, db_out_nxt;
	logic             oe_lo_r, oe_lo_nxt;
	logic             oe_hi_r, oe_hi_nxt;
	logic [7:0]       cmd_r, cmd_nxt;
	logic             stb_r, stb_nxt;
	logic             wr_done, rd_done, dp_done, cmd_done;
	logic             rd_ctl, rd_dp, w16, seq_dis, is_ldptr;
	logic [4:0]       cur_idx;
	logic [7:0]       status;
	logic [15:0]      db_d;

	// two-flop synchroniser; pin_d_r keeps the last sample for edge detect
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= PIN_RST;
			pin_s2_r <= PIN_RST;
			pin_d_r  <= PIN_RST;
		end else begin
			pin_s1_r <= {cs_n, rd_n, wr_n, cd, db_in};
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
		end
	end

	// strobe decode; chip select high blocks every transfer
	assign db_d     = pin_d_r[15:0];
	assign wr_done  = pin_s2_r[PIN_WR] && !pin_d_r[PIN_WR] && !pin_d_r[PIN_CS]
		&& pin_d_r[PIN_RD];                                             // R2 R23 R1
	assign rd_done  = pin_s2_r[PIN_RD] && !pin_d_r[PIN_RD] && !pin_d_r[PIN_CS]
		&& pin_d_r[PIN_WR] && !pin_d_r[PIN_CD];                         // R2 R22
	assign cmd_done = wr_done && pin_d_r[PIN_CD];                       // R4
	assign dp_done  = (wr_done && !pin_d_r[PIN_CD]) || rd_done;
	assign rd_ctl   = !pin_s2_r[PIN_CS] && pin_s2_r[PIN_CD] && !pin_s2_r[PIN_RD]
		&& pin_s2_r[PIN_WR];                                            // R4 R1
	assign rd_dp    = !pin_s2_r[PIN_CS] && !pin_s2_r[PIN_CD] && !pin_s2_r[PIN_RD]
		&& pin_s2_r[PIN_WR];                                            // R3 R1
	assign w16      = regs_r[IDX_GCTL][BUS_WIDTH_BIT];
	assign seq_dis  = regs_r[IDX_GCTL][SEQ_DIS_BIT];
	assign cur_idx  = reg_idx(grp_r, el_r);
	assign status   = {2'h0, cnt_out, bptr_r};
	assign is_ldptr = db_d[7:5] == CMD_LDPTR_TOP && db_d[2:0] != 3'h0;

	// register file, pointer, prefetch and command next state
	always_comb begin
		regs_nxt    = regs_r;
		grp_nxt     = grp_r;
		el_nxt      = el_r;
		bptr_nxt    = bptr_r;
		pf_pend_nxt = 1'b0;
		cmd_nxt     = cmd_r;
		stb_nxt     = cmd_done;
		pf_nxt      = pf_r;
		if (pf_pend_r) begin
			pf_nxt = (cur_idx == IDX_STATUS) ? {8'h00, status} :
				(cur_idx == IDX_NONE) ? REG_RST : regs_r[cur_idx];          // R22
		end
		if (wr_done && !pin_d_r[PIN_CD] && cur_idx < IDX_NONE) begin      // R3 R19
			if (w16) begin
				regs_nxt[cur_idx] = db_d;
			end else if (bptr_r) begin
				regs_nxt[cur_idx][7:0] = db_d[7:0];                         // R11
			end else begin
				regs_nxt[cur_idx][15:8] = db_d[7:0];
			end
		end
		if (dp_done) begin
			pf_pend_nxt = 1'b1;                                             // R22
			bptr_nxt    = w16 ? 1'b1 : !bptr_r;                             // R21
			if ((w16 || !bptr_r) && !seq_dis) begin
				{grp_nxt, el_nxt} = seq_next(grp_r, el_r);                  // R8
			end
		end
		if (cmd_done) begin
			cmd_nxt = db_d[7:0];
			if (is_ldptr) begin
				grp_nxt     = db_d[2:0];
				el_nxt      = db_d[4:3];
				bptr_nxt    = 1'b1;                                         // R7
				pf_pend_nxt = 1'b1;                                         // R22
			end
			case (db_d[7:0])
				CMD_MRESET:   regs_nxt[IDX_GCTL] = GCTL_RST;                 // R20
				CMD_FOUT_OFF: regs_nxt[IDX_GCTL][FOUT_GATE_BIT] = 1'b1;      // R9
				CMD_FOUT_ON:  regs_nxt[IDX_GCTL][FOUT_GATE_BIT] = 1'b0;      // R9
				CMD_BUS16:    regs_nxt[IDX_GCTL][BUS_WIDTH_BIT] = 1'b1;      // R9
				CMD_BUS8:     regs_nxt[IDX_GCTL][BUS_WIDTH_BIT] = 1'b0;      // R9
				CMD_SEQ_OFF:  regs_nxt[IDX_GCTL][SEQ_DIS_BIT] = 1'b1;        // R9
				CMD_SEQ_ON:   regs_nxt[IDX_GCTL][SEQ_DIS_BIT] = 1'b0;        // R9
				default:      regs_nxt[IDX_GCTL] = regs_nxt[IDX_GCTL];
			endcase
		end
	end

	// bus drivers: live status on control reads, prefetch on data reads
	always_comb begin
		db_out_nxt = DB_RST;
		oe_lo_nxt  = 1'b0;
		oe_hi_nxt  = 1'b0;
		if (rd_ctl) begin
			db_out_nxt = {8'h00, status};                                   // R10
			oe_lo_nxt  = 1'b1;
		end else if (rd_dp) begin
			oe_lo_nxt = 1'b1;
			if (w16) begin
				db_out_nxt = pf_r;                                          // R12 R13
				oe_hi_nxt  = 1'b1;
			end else if (bptr_r || cur_idx == IDX_STATUS) begin
				db_out_nxt = {8'h00, pf_r[7:0]};                            // R14
			end else begin
				db_out_nxt = {8'h00, pf_r[15:8]};                           // R12
			end
		end
	end

	// state registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_r[i] <= REG_RST;                                        // R20
			end
			grp_r     <= GRP_RST;
			el_r      <= EL_RST;
			bptr_r    <= 1'b1;
			pf_r      <= REG_RST;
			pf_pend_r <= 1'b1;
			db_out_r  <= DB_RST;
			oe_lo_r   <= 1'b0;
			oe_hi_r   <= 1'b0;
			cmd_r     <= CMD_RST;
			stb_r     <= 1'b0;
		end else begin
			regs_r    <= regs_nxt;
			grp_r     <= grp_nxt;
			el_r      <= el_nxt;
			bptr_r    <= bptr_nxt;
			pf_r      <= pf_nxt;
			pf_pend_r <= pf_pend_nxt;
			db_out_r  <= db_out_nxt;
			oe_lo_r   <= oe_lo_nxt;
			oe_hi_r   <= oe_hi_nxt;
			cmd_r     <= cmd_nxt;
			stb_r     <= stb_nxt;
		end
	end

	assign db_out         = db_out_r;
	assign db_oe_lo       = oe_lo_r;
	assign db_oe_hi       = oe_hi_r;
	assign global_control = regs_r[IDX_GCTL];
	assign cmd_code       = cmd_r;
	assign cmd_stb        = stb_r;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd_held;
		rd_dp [*3];
	endsequence
	sequence s_ctl_rd;
		rd_ctl ##1 rd_ctl;
	endsequence

	property p_cs_blocks;
		pin_s2_r[PIN_CS] |=> !oe_lo_r && !oe_hi_r;
	endproperty
	a_cs_blocks: assert property (p_cs_blocks) else $error("driven while deselected"); // R2
	property p_status_rd;
		s_ctl_rd |=> oe_lo_r && !oe_hi_r && db_out_r[7:0] == $past(status);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read wrong"); // R4 R10
	property p_ldptr;
		cmd_done && is_ldptr |=> bptr_r && grp_r == $past(db_d[2:0]) ##1 pf_pend_r == 1'b0;
	endproperty
	a_ldptr: assert property (p_ldptr) else $error("load pointer wrong"); // R7
	property p_narrow;
		rd_dp && !w16 |=> oe_lo_r && !oe_hi_r;
	endproperty
	a_narrow: assert property (p_narrow) else $error("high lines driven in 8-bit"); // R12
	property p_rd_stable;
		s_rd_held |=> $stable(db_out_r);
	endproperty
	a_rd_stable: assert property (p_rd_stable) else $error("read data moved"); // R13
	property p_mreset;
		cmd_done && db_d[7:0] == CMD_MRESET |=> global_control == GCTL_RST;
	endproperty
	a_mreset: assert property (p_mreset) else $error("master reset missed"); // R20
	property p_seq;
		dp_done && w16 && !seq_dis && el_r != EL_HOLDC && grp_r != GRP_CTL
			|=> {grp_r, el_r} != $past({grp_r, el_r});
	endproperty
	a_seq: assert property (p_seq) else $error("pointer did not advance"); // R8
	property p_bptr_toggle;
		dp_done && !w16 |=> bptr_r != $past(bptr_r) ##1 !pf_pend_r;
	endproperty
	a_bptr_toggle: assert property (p_bptr_toggle) else $error("byte pointer stuck"); // R21
	property p_one_write;
		cmd_done |=> cmd_stb ##1 !cmd_stb;
	endproperty
	a_one_write: assert property (p_one_write) else $error("double write"); // R23
	property p_seq_cmd;
		cmd_done && db_d[7:0] == CMD_SEQ_OFF |=> seq_dis ##1 seq_dis;
	endproperty
	a_seq_cmd: assert property (p_seq_cmd) else $error("sequencing bit not set"); // R9
endmodule : thbp_host_port

// File: testbench/thbp_host_model.sv
// thbp_host_model: behavioural host cpu on the strobe bus of the host port.
// assumes the port samples its pins on sys_clk; pins change at falling edges.
`timescale 1ns/1ps
module thbp_host_model (
	input  wire logic        sys_clk,  // bus clock
	input  wire logic [15:0] db_out,   // device drive value
	input  wire logic        db_oe_lo, // device drives 7:0
	input  wire logic        db_oe_hi, // device drives 15:8
	output logic             cs_n,     // chip select
	output logic             rd_n,     // read strobe
	output logic             wr_n,     // write strobe
	output logic             cd,       // control/data select
	output logic      [15:0] db_in     // resolved bus
);
	logic [15:0] host_v_r;  // last host value
	logic        host_oe_r; // host drives bus
	// resolved bus; released lines show the inverse of the last host value
	always_comb begin
		db_in[7:0]  = db_oe_lo ? db_out[7:0] : (host_oe_r ? host_v_r[7:0] : ~host_v_r[7:0]);
		db_in[15:8] = db_oe_hi ? db_out[15:8] : (host_oe_r ? host_v_r[15:8] : ~host_v_r[15:8]);
	end
	// idle pins
	initial begin
		cs_n      = 1'b1;
		rd_n      = 1'b1;
		wr_n      = 1'b1;
		cd        = 1'b0;
		host_v_r  = 16'h0000;
		host_oe_r = 1'b0;
	end
	// one strobe cycle; select lines stay asserted afterwards
	task automatic xfer(input logic sel_n, input logic ctl, input logic wr,
		input logic [15:0] wd, output logic [15:0] rd);
		@(negedge sys_clk);
		cs_n      = sel_n;
		cd        = ctl;
		host_v_r  = wd;
		host_oe_r = wr;
		@(negedge sys_clk);
		if (wr) begin
			wr_n = 1'b0;
		end else begin
			rd_n = 1'b0;
		end
		repeat (5) @(negedge sys_clk);
		rd   = db_in;
		rd_n = 1'b1;
		wr_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		host_oe_r = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask : xfer
endmodule : thbp_host_model

// File: testbench/thbp_host_port_bench.sv
// thbp_host_port_bench: self-checking bench for the timer host bus port.
// assumes the host model drives the pins; one 40 MHz clock.
`timescale 1ns/1ps
module thbp_host_port_bench;
	import thbp_pkg::*;
	logic        sys_clk;             // 40 MHz clock
	logic        rst_n;               // async reset
	logic        cs_n;                // chip select
	logic        rd_n;                // read strobe
	logic        wr_n;                // write strobe
	logic        cd;                  // control/data select
	logic [15:0] db_in;               // resolved bus
	logic [4:0]  cnt_out;             // counter outputs
	logic [15:0] db_out;              // device drive value
	logic        db_oe_lo;            // low byte enable
	logic        db_oe_hi;            // high byte enable
	logic [15:0] global_control;      // control register
	logic [7:0]  cmd_code;            // last command
	logic        cmd_stb;             // command pulse
	logic [15:0] rv;                  // last read value
	int          bad_count = 0;       // mismatches
	int          samples_checked = 0; // comparisons
	int          stb_cnt = 0;         // command pulses seen
	// clock
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	// count command pulses
	always @(negedge sys_clk) if (cmd_stb === 1'b1) stb_cnt++;
	thbp_host_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .cd(cd), .db_in(db_in), .cnt_out(cnt_out), .db_out(db_out),
		.db_oe_lo(db_oe_lo), .db_oe_hi(db_oe_hi), .global_control(global_control),
		.cmd_code(cmd_code), .cmd_stb(cmd_stb));
	thbp_host_model host (.sys_clk(sys_clk), .db_out(db_out), .db_oe_lo(db_oe_lo),
		.db_oe_hi(db_oe_hi), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .cd(cd), .db_in(db_in));
	// word compare
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16
	// command write, one pulse each
	task automatic cmd(input logic [7:0] code);
		int n;
		n = stb_cnt;
		host.xfer(1'b0, 1'b1, 1'b1, {8'hff, code}, rv);
		chk16(16'(stb_cnt - n), 16'h0001);
		chk16({8'h00, cmd_code}, {8'h00, code});
	endtask : cmd
	// data port write
	task automatic dw(input logic [15:0] v);
		host.xfer(1'b0, 1'b0, 1'b1, v, rv);
	endtask : dw
	// data port read; narrow reads leave the high lines released
	task automatic dr(input logic [15:0] exp, input logic wide);
		host.xfer(1'b0, 1'b0, 1'b0, 16'h0000, rv);
		if (wide) begin
			chk16(rv, exp);
		end else begin
			chk16({8'h00, rv[7:0]}, exp);
			chk16({8'h00, rv[15:8]}, {8'h00, ~host.host_v_r[15:8]});
		end
	endtask : dr
	task automatic t_reset();
		chk16(global_control, GCTL_RST);
		dr(16'h0000, 1'b0);
		cmd(8'h06);
		dw(16'he0a5);
		cmd(8'h06);
		dr(16'h0000, 1'b0);
		cmd(8'h07);
		dr(16'h0000, 1'b0);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_cs_high();
		int n;
		n = stb_cnt;
		host.xfer(1'b1, 1'b1, 1'b1, {8'hff, CMD_BUS16}, rv);
		chk16(16'(stb_cnt - n), 16'h0000);
		chk16(global_control, 16'h0000);
		$display("t_cs_high done");
	endtask : t_cs_high
	task automatic t_cmds();
		logic [7:0]  codes [6] = '{CMD_FOUT_OFF, CMD_FOUT_ON, CMD_SEQ_OFF, CMD_SEQ_ON,
			CMD_BUS16, CMD_BUS8};
		logic [15:0] exps [6] = '{16'h1000, 16'h0000, 16'h4000, 16'h0000, 16'h2000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			cmd(codes[i]);
			chk16(global_control, exps[i]);
		end
		cmd(CMD_FOUT_OFF);
		cmd(CMD_MRESET);
		chk16(global_control, GCTL_RST);
		$display("t_cmds done");
	endtask : t_cmds
	task automatic t_seq16();
		cmd(CMD_BUS16);
		cmd(8'h09);
		dw(16'h1111);
		dw(16'h2222);
		dw(16'h3333);
		cmd(8'h09);
		dr(16'h1111, 1'b1);
		dr(16'h2222, 1'b1);
		dr(16'h3333, 1'b1);
		$display("t_seq16 done");
	endtask : t_seq16
	task automatic t_gctl_hold();
		cmd(8'h17);
		dw(16'h6000);
		chk16(global_control, 16'h6000);
		cmd(8'h1a);
		dw(16'hbeef);
		cmd(8'h12);
		dr(16'hbeef, 1'b1);
		dr(16'hbeef, 1'b1);
		$display("t_gctl_hold done");
	endtask : t_gctl_hold
	task automatic t_byte8();
		cmd(CMD_SEQ_ON);
		cmd(CMD_BUS8);
		cmd(8'h09);
		dw(16'he034);
		dw(16'he012);
		cmd(8'h09);
		dr(16'h0034, 1'b0);
		dr(16'h0012, 1'b0);
		dr(16'h0022, 1'b0);
		$display("t_byte8 done");
	endtask : t_byte8
	task automatic t_status();
		cnt_out = 5'h15;
		cmd(8'h1f);
		for (int i = 0; i < 2; i++) begin
			host.xfer(1'b0, 1'b0, 1'b0, 16'h0000, rv);
			chk16({9'h000, rv[7:1]}, 16'h0015);
		end
		fork
			host.xfer(1'b0, 1'b1, 1'b0, 16'h0000, rv);
			begin
				repeat (5) @(negedge sys_clk);
				chk16({11'h000, db_in[5:1]}, 16'h0015);
				cnt_out = 5'h0a;
			end
		join
		chk16({9'h000, rv[7:1]}, 16'h000a);
		$display("t_status done");
	endtask : t_status
	// verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	// main sequence
	initial begin
		rst_n   = 1'b0;
		cnt_out = 5'h00;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		t_reset();
		t_cs_high();
		t_cmds();
		t_seq16();
		t_gctl_hold();
		t_byte8();
		t_status();
		report_and_stop();
	end
	// watchdog, well beyond the expected run of about 650 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		report_and_stop();
	end
endmodule : thbp_host_port_bench
